// >>> verif/sbf_serial_unit_sva.sv
module sbf_serial_unit_sva #(
  parameter int ADDR_W = 24,
  parameter int FRAME_DEPTH = 4
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [ADDR_W-1:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic tx_empty_irq, // tx irq
  input wire logic rx_full_irq // rx irq
);
  // ----------------------------------------
  // control shadow
  // ----------------------------------------
  logic [ADDR_W-3:0] idx;
  logic mapped;
  logic en_r;
  logic txonly_r;
  assign idx = wb_adr_i[ADDR_W-1:2];
  assign mapped = idx >= sbf_pkg::CONTROL_IDX && idx <= sbf_pkg::SERIAL_DATA_IDX;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      en_r <= 1'b0;
      txonly_r <= 1'b0;
    end
    else if (wb_ack_o && wb_we_i && idx == sbf_pkg::CONTROL_IDX && wb_sel_i[0])
    begin
      en_r <= wb_dat_i[sbf_pkg::CTL_ENABLE_BIT];
      txonly_r <= wb_dat_i[sbf_pkg::CTL_TXONLY_BIT];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_stb_i);
  endproperty
  property p_st_rsvd;
    s_rd and (idx == sbf_pkg::SERIAL_STATUS_IDX) |-> !wb_dat_o[4] && !wb_dat_o[6];
  endproperty
  property p_txe_off;
    s_rd and (idx == sbf_pkg::SERIAL_STATUS_IDX && !en_r) |-> wb_dat_o[5];
  endproperty
  property p_unmapped;
    s_rd and (!mapped) |-> wb_dat_o == 32'h0;
  endproperty
  property p_txi_pulse;
    tx_empty_irq |=> !tx_empty_irq;
  endproperty
  property p_rxi_pulse;
    rx_full_irq |=> !rx_full_irq;
  endproperty
  property p_txi_en;
    tx_empty_irq |-> en_r;
  endproperty
  property p_rxi_dup;
    rx_full_irq |-> en_r && !txonly_r;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  a_st_rsvd: assert property (p_st_rsvd) else $error("reserved status bit set");
  a_txe_off: assert property (p_txe_off) else $error("tx empty low while off");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_txi_pulse: assert property (p_txi_pulse) else $error("tx irq not a pulse");
  a_rxi_pulse: assert property (p_rxi_pulse) else $error("rx irq not a pulse");
  a_txi_en: assert property (p_txi_en) else $error("tx irq while off");
  a_rxi_dup: assert property (p_rxi_dup) else $error("rx irq in tx only");
endmodule

bind sbf_serial_unit sbf_serial_unit_sva #(.ADDR_W(ADDR_W), .FRAME_DEPTH(FRAME_DEPTH)) u_sva (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_empty_irq(tx_empty_irq),
  .rx_full_irq(rx_full_irq)
);

// >>> verif/sbf_serial_unit_tb.sv
module sbf_serial_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [23:0] wb_adr_i = 24'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sck, mosi, ssel_n, miso_out, miso_oe, miso_line, tx_empty_irq, rx_full_irq;
  logic miso_last = 1'b0;
  logic [31:0] q, t0, t1;
  logic [15:0] w;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int miscompares = 0;
  int checks = 0;
  int txi = 0;
  int rxi = 0;
  integer seed = 32'hd2d1;
  localparam logic [21:0] ST = sbf_pkg::SERIAL_STATUS_IDX;
  localparam logic [21:0] DAT = sbf_pkg::SERIAL_DATA_IDX;
  localparam logic [21:0] DC = sbf_pkg::DATA_CONTROL_IDX;
  localparam logic [21:0] CTL = sbf_pkg::CONTROL_IDX;

  sbf_serial_unit dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_in(sck),
    .mosi_in(mosi), .ssel_n_in(ssel_n), .miso_out(miso_out), .miso_oe(miso_oe),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq));
  sbf_spi_peer peer (.sck(sck), .mosi(mosi), .ssel_n(ssel_n), .miso(miso_line));

  // undriven line shows the inverse of its last level
  assign miso_line = miso_oe ? miso_out : ~miso_last;
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (miso_oe === 1'b1) miso_last <= miso_out;
    if (tx_empty_irq === 1'b1) txi++;
    if (rx_full_irq === 1'b1) rxi++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [21:0] idx, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [21:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [21:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(q, exp);
  endtask
  task automatic xfer(input logic [15:0] d, input int nb);
    peer.send(d, nb);
    repeat (10) @(posedge core_clk);
  endtask
  function automatic logic [31:0] st(input int o, input int m, input int t, input int r);
    return 32'(o + 4 * m + 32 * t + 128 * r);
  endfunction

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rdc(ST, st(0, 0, 1, 0)); // status after reset
    rdc(22'h000010, 32'h0); // unmapped read
    wr(CTL, 32'h1);
    wr(DC, 32'h11);
    wr(sbf_pkg::COMMAND_SLOT_IDX, 32'h7); // eight bit frames
    t0 = $random(seed);
    t1 = $random(seed);
    wr(DAT, t0); // load while empty
    rdc(DAT, t0); // read back last write
    rdc(ST, st(0, 0, 1, 0)); // one frame short
    wr(DAT, t1);
    txq.push_back(t0[7:0]);
    txq.push_back(t1[7:0]);
    rdc(ST, st(0, 0, 0, 0)); // both frames written
    rdc(DAT, 32'h0); // read back hidden
    wr(DAT, ~t0); // write while full
    w = 16'($random(seed));
    xfer(w, 16);
    check(32'(peer.got), {16'h0, txq[0], txq[1]}); // sent data
    check(32'(txi), 32'h1); // one empty request
    check(32'(rxi), 32'h1); // one full request
    rdc(ST, st(0, 0, 1, 1)); // flags after transfer
    rdc(DAT, t1); // last accepted write shown after the load
    rxq.push_back(w[15:8]);
    rxq.push_back(w[7:0]);
    xfer(~w, 16);
    rdc(ST, st(1, 0, 1, 1)); // overrun on unread data
    check(32'(rxi), 32'h1); // no full request on overrun
    wr(ST, 32'ha1); // keep hardware bits at one
    wr(ST, 32'ha0);
    rdc(ST, st(1, 0, 1, 1)); // no clear without read
    wr(ST, 32'ha0);
    wr(DC, 32'h01);
    rdc(DAT, 32'(rxq.pop_front())); // first frame kept
    rdc(DAT, 32'(rxq.pop_front())); // second frame kept
    rdc(ST, st(0, 0, 1, 0)); // cleared after reads
    xfer(w, 4);
    rdc(ST, st(0, 1, 1, 0)); // aborted frame
    wr(ST, 32'ha0);
    rdc(ST, st(0, 0, 1, 0)); // mode fault cleared
    wr(CTL, 32'h3);
    xfer(w, 16);
    rdc(ST, st(0, 0, 1, 0)); // no receive in tx only
    check(32'(rxi), 32'h1); // no full request in tx only
    wr(DAT, t0);
    wr(DAT, t1);
    rdc(ST, st(0, 0, 0, 0)); // buffer loaded
    wr(CTL, 32'h0);
    rdc(ST, st(0, 0, 1, 0)); // empty while off
    complete_run();
  end
endmodule

// >>> verif/sbf_spi_peer.sv
module sbf_spi_peer (
  output logic sck, // link clock
  output logic mosi, // data to unit
  output logic ssel_n, // select, active low
  input wire logic miso // data from unit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got;
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
    ssel_n = 1'b1;
    got = 16'h0;
  end
  // ----------------------------------------
  // mode 0 master, msb first, clock low between frames
  // ----------------------------------------
  task automatic send(input logic [15:0] w, input int nb);
    #3 ssel_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      mosi = w[15-i];
      #40 sck = 1'b1;
      got = {got[14:0], miso};
      #40 sck = 1'b0;
    end
    #40 ssel_n = 1'b1;
    // released line must not keep its last level
    mosi = ~mosi;
  endtask
endmodule

// >>> verilog/sbf_pkg.sv
package sbf_pkg;

  // --------------------------------------------------------------------------
  // register word indexes (byte address = index * 4)
  // --------------------------------------------------------------------------
  localparam int IDX_W = 22;
  localparam logic [IDX_W-1:0] CONTROL_IDX = 22'h088380;
  localparam logic [IDX_W-1:0] DATA_CONTROL_IDX = 22'h088381;
  localparam logic [IDX_W-1:0] COMMAND_SLOT_IDX = 22'h088382;
  localparam logic [IDX_W-1:0] SERIAL_STATUS_IDX = 22'h088383;
  localparam logic [IDX_W-1:0] SERIAL_DATA_IDX = 22'h088384;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_TXONLY_BIT = 1;
  localparam int CTL_PARITY_BIT = 2;
  localparam int DC_FC_LSB = 0;
  localparam int DC_RDSEL_BIT = 4;
  localparam int DC_LONG_BIT = 5;
  localparam int CMD_LEN_LSB = 0;
  localparam int ST_OVERRUN_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_MODE_FAULT_FLAG_BIT = 2;
  localparam int ST_PARITY_BIT = 3;
  localparam int ST_TXEMPTY_BIT = 5;
  localparam int ST_RXFULL_BIT = 7;

  // --------------------------------------------------------------------------
  // reset values and frame lengths
  // --------------------------------------------------------------------------
  localparam logic [2:0] CONTROL_RST = 3'h0;
  localparam logic [1:0] FRAME_COUNT_RST = 2'h0;
  localparam logic [3:0] DATA_LENGTH_RST = 4'h7;
  localparam logic [3:0] LEN_CODE_MIN = 4'h4;
  localparam logic [3:0] LEN_CODE_WIDE = 4'h8;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_20 = 6'h14;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_32 = 6'h20;
  localparam logic [5:0] LEN_ONE = 6'h01;

endpackage

// >>> verilog/sbf_serial_unit.sv
// Our own choice: the Wishbone interface to the registers.
module sbf_serial_unit #(
  parameter int ADDR_W = 24,
  parameter int FRAME_DEPTH = 4
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic sck_in, // serial clock from peer
  input wire logic mosi_in, // serial data in
  input wire logic ssel_n_in, // slave select, active low
  output logic miso_out, // serial data out
  output logic miso_oe, // serial data out enable
  output logic tx_empty_irq, // tx buffer empty request pulse
  output logic rx_full_irq // rx buffer full request pulse
);

  if (FRAME_DEPTH != 4 || ADDR_W < 24)
  begin
    $error("sbf_serial_unit: unsupported FRAME_DEPTH or ADDR_W");
  end

  // --------------------------------------------------------------------------
  // frame length from data length code
  // --------------------------------------------------------------------------
  function automatic logic [5:0] frame_len(input logic [3:0] code, input logic lw);
    logic [5:0] len;
    len = sbf_pkg::LEN_BYTE;
    if (lw && code < sbf_pkg::LEN_CODE_MIN)
    begin
      if (code == 4'h0)
        len = sbf_pkg::LEN_20;
      else if (code == 4'h1)
        len = sbf_pkg::LEN_24;
      else
        len = sbf_pkg::LEN_32;
    end
    else if (code >= sbf_pkg::LEN_CODE_WIDE)
    begin
      len = {2'h0, code} + sbf_pkg::LEN_ONE;
    end
    return len;
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic mosi_s1_r, mosi_s2_r;
  logic ssel_n_s1_r, ssel_n_s2_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      ssel_n_s1_r <= 1'b1;
      ssel_n_s2_r <= 1'b1;
    end
    else
    begin
      sck_s1_r <= sck_in;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      mosi_s1_r <= mosi_in;
      mosi_s2_r <= mosi_s1_r;
      ssel_n_s1_r <= ssel_n_in;
      ssel_n_s2_r <= ssel_n_s1_r;
    end
  end

  // --------------------------------------------------------------------------
  // state declarations
  // --------------------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  logic enable_r, txonly_r, parity_en_r;
  logic [1:0] frame_count_r;
  logic read_src_r, long_word_r;
  logic [3:0] data_length_r;
  logic overrun_r, mode_fault_flag_r, perr_r, tx_empty_r, rx_full_r;
  logic arm_ovr_r, arm_mode_fault_flag_r, arm_perr_r;
  logic [31:0] tx_buf [FRAME_DEPTH];
  logic [31:0] rx_buf [FRAME_DEPTH];
  logic [31:0] last_written_r;
  logic [1:0] tx_wr_ptr_r, tx_rd_ptr_r, rx_wr_ptr_r, rx_rd_ptr_r;
  logic shift_loaded_r;
  logic [31:0] shift_out_r, shift_in_r;
  logic [5:0] bit_cnt_r;
  logic miso_r, miso_oe_r, tx_irq_r, rx_irq_r;

  // --------------------------------------------------------------------------
  // decode and event terms
  // --------------------------------------------------------------------------
  logic req, wr_acc, rd_acc;
  logic [sbf_pkg::IDX_W-1:0] idx;
  logic hit_ctl, hit_dc, hit_cmd, hit_st, hit_data;
  logic [5:0] len;
  logic sck_rise, sck_fall, selected;
  logic tx_accept, tx_last_wr, load_go, load_last;
  logic [31:0] shift_in_nxt;
  logic frame_done, frame_abort, rx_store, rx_last, ovr_set, perr_set;
  logic data_rd, rx_rd_last, st_wr;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_acc = req & wb_we_i;
  assign rd_acc = req & ~wb_we_i;
  assign idx = wb_adr_i[sbf_pkg::IDX_W+1:2];
  assign hit_ctl = idx == sbf_pkg::CONTROL_IDX;
  assign hit_dc = idx == sbf_pkg::DATA_CONTROL_IDX;
  assign hit_cmd = idx == sbf_pkg::COMMAND_SLOT_IDX;
  assign hit_st = idx == sbf_pkg::SERIAL_STATUS_IDX;
  assign hit_data = idx == sbf_pkg::SERIAL_DATA_IDX;
  assign len = frame_len(data_length_r, long_word_r);
  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign sck_fall = ~sck_s2_r & sck_s3_r;
  assign selected = enable_r & ~ssel_n_s2_r;
  // writes count only while the buffer is empty
  assign tx_accept = wr_acc & hit_data & (wb_sel_i != 4'h0) & tx_empty_r & enable_r;
  assign tx_last_wr = tx_accept & (tx_wr_ptr_r == frame_count_r);
  // frames move to the shifter only between frames
  assign load_go = enable_r & ~tx_empty_r & ~shift_loaded_r & (bit_cnt_r == 6'h00);
  assign load_last = load_go & (tx_rd_ptr_r == frame_count_r);
  assign shift_in_nxt = {shift_in_r[30:0], mosi_s2_r};
  assign frame_done = selected & sck_rise & (bit_cnt_r == len - sbf_pkg::LEN_ONE);
  assign frame_abort = ssel_n_s2_r & (bit_cnt_r != 6'h00);
  // store only while the buffer is not full and no overrun is flagged, in full duplex
  assign rx_store = frame_done & ~txonly_r & ~rx_full_r & ~overrun_r;
  // rx-full once the selected frame count is stored
  assign rx_last = rx_store & (rx_wr_ptr_r == frame_count_r);
  // unread data present, new frame is lost
  assign ovr_set = frame_done & ~txonly_r & rx_full_r;
  assign perr_set = frame_done & parity_en_r & ^shift_in_nxt;
  // data reads from the rx side only when selected
  assign data_rd = rd_acc & hit_data & ~read_src_r;
  assign rx_rd_last = data_rd & rx_full_r & (rx_rd_ptr_r == frame_count_r);
  assign st_wr = wr_acc & hit_st & wb_sel_i[0];

  // --------------------------------------------------------------------------
  // bus answer
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else if (rd_acc)
    begin
      rdata_r <= 32'h0000_0000;
      if (hit_ctl)
      begin
        rdata_r[sbf_pkg::CTL_ENABLE_BIT] <= enable_r;
        rdata_r[sbf_pkg::CTL_TXONLY_BIT] <= txonly_r;
        rdata_r[sbf_pkg::CTL_PARITY_BIT] <= parity_en_r;
      end
      else if (hit_dc)
      begin
        rdata_r[sbf_pkg::DC_FC_LSB+:2] <= frame_count_r;
        rdata_r[sbf_pkg::DC_RDSEL_BIT] <= read_src_r;
        rdata_r[sbf_pkg::DC_LONG_BIT] <= long_word_r;
      end
      else if (hit_cmd)
        rdata_r[sbf_pkg::CMD_LEN_LSB+:4] <= data_length_r;
      else if (hit_st)
      begin
        // status layout, b4 and b6 stay zero
        rdata_r[sbf_pkg::ST_OVERRUN_BIT] <= overrun_r;
        rdata_r[sbf_pkg::ST_ACTIVE_BIT] <= ~ssel_n_s2_r | (bit_cnt_r != 6'h00);
        rdata_r[sbf_pkg::ST_MODE_FAULT_FLAG_BIT] <= mode_fault_flag_r;
        rdata_r[sbf_pkg::ST_PARITY_BIT] <= perr_r;
        rdata_r[sbf_pkg::ST_TXEMPTY_BIT] <= tx_empty_r;
        rdata_r[sbf_pkg::ST_RXFULL_BIT] <= rx_full_r;
      end
      else if (hit_data)
      begin
        if (!read_src_r)
          rdata_r <= rx_buf[rx_rd_ptr_r];
        // tx read-back is zero while a transfer is pending
        else if (tx_empty_r)
          rdata_r <= last_written_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      {parity_en_r, txonly_r, enable_r} <= sbf_pkg::CONTROL_RST;
      frame_count_r <= sbf_pkg::FRAME_COUNT_RST;
      read_src_r <= 1'b0;
      long_word_r <= 1'b0;
      data_length_r <= sbf_pkg::DATA_LENGTH_RST;
    end
    else if (wr_acc && wb_sel_i[0])
    begin
      if (hit_ctl)
      begin
        enable_r <= wb_dat_i[sbf_pkg::CTL_ENABLE_BIT];
        txonly_r <= wb_dat_i[sbf_pkg::CTL_TXONLY_BIT];
        parity_en_r <= wb_dat_i[sbf_pkg::CTL_PARITY_BIT];
      end
      if (hit_dc)
      begin
        // up to four frames per activation
        frame_count_r <= wb_dat_i[sbf_pkg::DC_FC_LSB+:2];
        read_src_r <= wb_dat_i[sbf_pkg::DC_RDSEL_BIT];
        long_word_r <= wb_dat_i[sbf_pkg::DC_LONG_BIT];
      end
      if (hit_cmd)
        data_length_r <= wb_dat_i[sbf_pkg::CMD_LEN_LSB+:4];
    end
  end

  // --------------------------------------------------------------------------
  // software-cleared error flags
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      arm_ovr_r <= 1'b0;
      arm_mode_fault_flag_r <= 1'b0;
      arm_perr_r <= 1'b0;
    end
    else if (rd_acc && hit_st)
    begin
      arm_ovr_r <= overrun_r;
      arm_mode_fault_flag_r <= mode_fault_flag_r;
      arm_perr_r <= perr_r;
    end
    else if (st_wr)
    begin
      arm_ovr_r <= 1'b0;
      arm_mode_fault_flag_r <= 1'b0;
      arm_perr_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      overrun_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      perr_r <= 1'b0;
    end
    else
    begin
      // hardware set beats a clear in the same cycle
      if (ovr_set)
        overrun_r <= 1'b1;
      // clear needs a 0 written after reading 1
      else if (st_wr && arm_ovr_r && !wb_dat_i[sbf_pkg::ST_OVERRUN_BIT])
        overrun_r <= 1'b0;
      if (frame_abort)
        mode_fault_flag_r <= 1'b1;
      else if (st_wr && arm_mode_fault_flag_r && !wb_dat_i[sbf_pkg::ST_MODE_FAULT_FLAG_BIT])
        mode_fault_flag_r <= 1'b0;
      if (perr_set)
        perr_r <= 1'b1;
      else if (st_wr && arm_perr_r && !wb_dat_i[sbf_pkg::ST_PARITY_BIT])
        perr_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // buffer flags (writes to b5 and b7 have no effect)
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tx_empty_r <= 1'b1;
    // disabled unit shows an empty buffer
    else if (!enable_r)
      tx_empty_r <= 1'b1;
    // last frame moved into the shifter
    else if (load_last)
      tx_empty_r <= 1'b1;
    else if (tx_last_wr)
      tx_empty_r <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rx_full_r <= 1'b0;
    // rx_last already excludes the overrun state
    else if (rx_last)
      rx_full_r <= 1'b1;
    // cleared after the last frame is read
    else if (rx_rd_last)
      rx_full_r <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // transmit buffer
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (tx_accept)
      tx_buf[tx_wr_ptr_r] <= wb_dat_i;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_wr_ptr_r <= 2'h0;
      last_written_r <= 32'h0000_0000;
    end
    else
    begin
      if (!enable_r || tx_last_wr)
        tx_wr_ptr_r <= 2'h0;
      else if (tx_accept)
        tx_wr_ptr_r <= tx_wr_ptr_r + 2'h1;
      // last accepted word, the final frame of a batch included
      if (tx_accept)
        last_written_r <= wb_dat_i;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tx_rd_ptr_r <= 2'h0;
    else if (!enable_r || load_last)
      tx_rd_ptr_r <= 2'h0;
    else if (load_go)
      tx_rd_ptr_r <= tx_rd_ptr_r + 2'h1;
  end

  // --------------------------------------------------------------------------
  // shift engine, sampled serial clock, msb first
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      shift_loaded_r <= 1'b0;
    else if (!enable_r || frame_done)
      shift_loaded_r <= 1'b0;
    else if (load_go)
      shift_loaded_r <= 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      shift_out_r <= 32'h0000_0000;
    else if (load_go)
      shift_out_r <= tx_buf[tx_rd_ptr_r] << (sbf_pkg::LEN_32 - len);
    // trailing fall of a frame must not push out the next frame's first bit
    else if (selected && sck_fall && bit_cnt_r != 6'h00)
      shift_out_r <= {shift_out_r[30:0], 1'b0};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_r <= 6'h00;
      shift_in_r <= 32'h0000_0000;
    end
    else if (!selected || frame_done)
    begin
      bit_cnt_r <= 6'h00;
      shift_in_r <= 32'h0000_0000;
    end
    else if (sck_rise)
    begin
      bit_cnt_r <= bit_cnt_r + sbf_pkg::LEN_ONE;
      shift_in_r <= shift_in_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // receive buffer
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rx_store)
      rx_buf[rx_wr_ptr_r] <= shift_in_nxt;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rx_wr_ptr_r <= 2'h0;
    else if (rx_last)
      rx_wr_ptr_r <= 2'h0;
    else if (rx_store)
      rx_wr_ptr_r <= rx_wr_ptr_r + 2'h1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rx_rd_ptr_r <= 2'h0;
    else if (rx_rd_last)
      rx_rd_ptr_r <= 2'h0;
    else if (data_rd && rx_full_r)
      rx_rd_ptr_r <= rx_rd_ptr_r + 2'h1;
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
      tx_irq_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end
    else
    begin
      miso_r <= shift_out_r[31];
      miso_oe_r <= selected;
      // empty request with the flag set
      tx_irq_r <= load_last & enable_r;
      // full request with the flag set
      rx_irq_r <= rx_last;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign miso_out = miso_r;
  assign miso_oe = miso_oe_r;
  assign tx_empty_irq = tx_irq_r;
  assign rx_full_irq = rx_irq_r;

endmodule
